// ---- core/smbsr_line_mon.sv ----
`timescale 1ns/1ps
`default_nettype none

module smbsr_line_mon (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output var  smbsr_pkg::smbsr_line_evt_t line_evt_o
);

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic       scl_prev_r;
    logic       sda_prev_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    // Conditions only count while the clock line stays high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_evt_o <= '0;
        end else begin
            line_evt_o.start    <= scl_sync_r[1] & scl_prev_r &
                                   sda_prev_r & ~sda_sync_r[1];
            line_evt_o.stop     <= scl_sync_r[1] & scl_prev_r &
                                   ~sda_prev_r & sda_sync_r[1];
            line_evt_o.scl_rise <= scl_sync_r[1] & ~scl_prev_r;
        end
    end

endmodule

`default_nettype wire

// ---- core/smbsr_pkg.sv ----
package smbsr_pkg;

    // Register byte offsets
    localparam logic [7:0]  STATUS_OFS     = 8'hac;
    localparam logic [7:0]  IRQ_MASK_OFS   = 8'hb8;

    // Field positions of the status word
    localparam int          SLV_ADDR_LSB   = 1;
    localparam int          MST_ADDR_LSB   = 9;
    localparam int          BOOT_DONE_BIT  = 24;
    localparam int          NACK_ERR_BIT   = 25;
    localparam int          ARB_ERR_BIT    = 26;
    localparam int          MISPL_ERR_BIT  = 27;
    localparam int          CSUM_ERR_BIT   = 28;

    // Sticky error flags, bits 28:25
    localparam logic [31:0] ERR_FLAG_MASK  = 32'h1e00_0000;
    localparam logic [31:0] STATUS_RST     = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RST   = 32'h0000_0000;
    localparam logic [6:0]  ADDR_RST       = 7'h00;

    // Counts
    localparam int          ARB_LOSS_LIMIT = 16;
    localparam logic [3:0]  SLOTS_PER_BYTE = 4'h9;

    typedef struct packed {
        logic xfer_start;
        logic arb_won;
        logic arb_lost;
        logic nack_unexp;
    } smbsr_mst_evt_t;

    typedef struct packed {
        logic load_done;
        logic csum_bad;
        logic no_cfg_done;
    } smbsr_load_evt_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
    } smbsr_line_evt_t;

endpackage

// ---- core/smbsr_top.sv ----
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module smbsr_top #(
    parameter int ARB_LIMIT = smbsr_pkg::ARB_LOSS_LIMIT
) (
    input  wire logic                        MCLK_I,
    input  wire logic                        NRST_I,
    input  wire logic                        WB_CYC_I,
    input  wire logic                        WB_STB_I,
    input  wire logic                        WB_WE_I,
    input  wire logic [7:0]                  WB_ADR_I,
    input  wire logic [3:0]                  WB_SEL_I,
    input  wire logic [31:0]                 WB_DAT_I,
    output var  logic [31:0]                 WB_DAT_O,
    output var  logic                        WB_ACK_O,
    input  wire logic [6:0]                  TARGET_ADDR_STRAP_I,
    input  wire logic [6:0]                  INITIATOR_ADDR_STRAP_I,
    input  wire logic                        BOOT_LOAD_MODE_I,
    input  wire smbsr_pkg::smbsr_mst_evt_t   MST_EVT_I,
    input  wire smbsr_pkg::smbsr_load_evt_t  LOAD_EVT_I,
    input  wire logic                        MST_SCL_I,
    input  wire logic                        MST_SDA_I,
    output var  logic                        ARB_RETRY_O,
    output var  logic                        XFER_ABORT_O,
    output var  logic                        IRQ_O
);

    localparam logic [4:0] ARB_LAST = 5'(ARB_LIMIT - 1);

    logic [6:0]  strap_tgt_s1_r;
    logic [6:0]  strap_tgt_s2_r;
    logic [6:0]  strap_ini_s1_r;
    logic [6:0]  strap_ini_s2_r;
    logic [1:0]  strap_mode_r;
    logic [1:0]  cap_dly_r;
    logic        cap_done_r;
    logic [6:0]  target_port_address_r;
    logic [6:0]  initiator_port_address_r;
    logic        boot_load_en_r;

    logic        boot_load_finished_r;
    logic        no_ack_error_flag_r;
    logic        arbitration_loss_error_flag_r;
    logic        misplaced_condition_error_flag_r;
    logic        boot_checksum_error_flag_r;
    logic [31:0] irq_mask_r;

    logic [4:0]  arb_loss_cnt_r;
    logic        mst_busy_r;
    logic [3:0]  slot_cnt_r;
    logic        byte_seen_r;
    logic        arb_abort;
    logic        misplaced;

    logic        bus_req;
    logic        wr_commit;
    logic        hit_status;
    logic        hit_mask;
    logic [31:0] w1c_clr;
    logic [31:0] serial_bus_status_reg;
    logic [31:0] rd_data_nxt;

    smbsr_pkg::smbsr_line_evt_t line_evt;

    smbsr_line_mon u_line_mon (
        .clk_i      (MCLK_I),
        .rst_n_i    (NRST_I),
        .scl_i      (MST_SCL_I),
        .sda_i      (MST_SDA_I),
        .line_evt_o (line_evt)
    );

    function automatic logic word_hit(input logic [7:0] adr,
                                      input logic [7:0] ofs);
        word_hit = (adr[7:2] == ofs[7:2]);
    endfunction

    // Straps are pins: two flops before capture
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            strap_tgt_s1_r <= smbsr_pkg::ADDR_RST;
            strap_tgt_s2_r <= smbsr_pkg::ADDR_RST;
            strap_ini_s1_r <= smbsr_pkg::ADDR_RST;
            strap_ini_s2_r <= smbsr_pkg::ADDR_RST;
            strap_mode_r   <= 2'h0;
        end else begin
            strap_tgt_s1_r <= TARGET_ADDR_STRAP_I;
            strap_tgt_s2_r <= strap_tgt_s1_r;
            strap_ini_s1_r <= INITIATOR_ADDR_STRAP_I;
            strap_ini_s2_r <= strap_ini_s1_r;
            strap_mode_r   <= {strap_mode_r[0], BOOT_LOAD_MODE_I};
        end
    end

    // Capture once, after the synchronisers have filled
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cap_dly_r                <= 2'h0;
            cap_done_r               <= 1'b0;
            target_port_address_r    <= smbsr_pkg::ADDR_RST;
            initiator_port_address_r <= smbsr_pkg::ADDR_RST;
            boot_load_en_r           <= 1'b0;
        end else begin
            cap_dly_r <= {cap_dly_r[0], 1'b1};
            if (cap_dly_r[1] && !cap_done_r) begin
                cap_done_r               <= 1'b1;
                target_port_address_r    <= strap_tgt_s2_r;
                initiator_port_address_r <= strap_ini_s2_r;
                boot_load_en_r           <= strap_mode_r[1];
            end
        end
    end

    // Wishbone: ack one cycle after the request, commit on ack edge
    assign bus_req    = WB_CYC_I & WB_STB_I;
    assign wr_commit  = bus_req & WB_WE_I & WB_ACK_O;
    assign hit_status = word_hit(WB_ADR_I, smbsr_pkg::STATUS_OFS);
    assign hit_mask   = word_hit(WB_ADR_I, smbsr_pkg::IRQ_MASK_OFS);
    assign w1c_clr    = (wr_commit && hit_status && WB_SEL_I[3]) ?
                        (WB_DAT_I & smbsr_pkg::ERR_FLAG_MASK) : 32'h0;

    always_comb begin
        serial_bus_status_reg = smbsr_pkg::STATUS_RST;
        serial_bus_status_reg[smbsr_pkg::SLV_ADDR_LSB +: 7] =
            target_port_address_r;
        serial_bus_status_reg[smbsr_pkg::MST_ADDR_LSB +: 7] =
            initiator_port_address_r;
        serial_bus_status_reg[smbsr_pkg::BOOT_DONE_BIT] =
            boot_load_finished_r;
        serial_bus_status_reg[smbsr_pkg::NACK_ERR_BIT] =
            no_ack_error_flag_r;
        serial_bus_status_reg[smbsr_pkg::ARB_ERR_BIT] =
            arbitration_loss_error_flag_r;
        serial_bus_status_reg[smbsr_pkg::MISPL_ERR_BIT] =
            misplaced_condition_error_flag_r;
        serial_bus_status_reg[smbsr_pkg::CSUM_ERR_BIT] =
            boot_checksum_error_flag_r;
    end

    always_comb begin
        rd_data_nxt = 32'h0;
        if (hit_status) begin
            rd_data_nxt = serial_bus_status_reg;
        end else if (hit_mask) begin
            rd_data_nxt = irq_mask_r;
        end
    end

    // Unmapped addresses still ack, reading zero
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
            if (bus_req && !WB_ACK_O && !WB_WE_I) begin
                WB_DAT_O <= rd_data_nxt;
            end
        end
    end

    // only flag bits of the mask are writable
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_mask_r <= smbsr_pkg::IRQ_MASK_RST;
        end else if (wr_commit && hit_mask && WB_SEL_I[3]) begin
            irq_mask_r <= WB_DAT_I & smbsr_pkg::ERR_FLAG_MASK;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            boot_load_finished_r <= 1'b0;
        end else if (boot_load_en_r && |LOAD_EVT_I) begin
            boot_load_finished_r <= 1'b1;
        end
    end

    // Arbitration loss counter
    assign arb_abort = MST_EVT_I.arb_lost && (arb_loss_cnt_r == ARB_LAST);

    // retry until the limit, then abort
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            arb_loss_cnt_r <= 5'h0;
            ARB_RETRY_O    <= 1'b0;
            XFER_ABORT_O   <= 1'b0;
        end else begin
            ARB_RETRY_O  <= MST_EVT_I.arb_lost & ~arb_abort;
            XFER_ABORT_O <= arb_abort;
            if (MST_EVT_I.xfer_start || MST_EVT_I.arb_won || arb_abort) begin
                arb_loss_cnt_r <= 5'h0;
            end else if (MST_EVT_I.arb_lost) begin
                arb_loss_cnt_r <= arb_loss_cnt_r + 5'h1;
            end
        end
    end

    // Bit slot tracking inside a master transfer
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mst_busy_r  <= 1'b0;
            slot_cnt_r  <= 4'h0;
            byte_seen_r <= 1'b0;
        end else begin
            if (MST_EVT_I.xfer_start) begin
                mst_busy_r <= 1'b1;
            end else if (arb_abort || line_evt.stop) begin
                mst_busy_r <= 1'b0;
            end
            if (line_evt.start || line_evt.stop) begin
                slot_cnt_r  <= 4'h0;
                byte_seen_r <= 1'b0;
            end else if (line_evt.scl_rise) begin
                if (slot_cnt_r == smbsr_pkg::SLOTS_PER_BYTE - 4'h1) begin
                    slot_cnt_r  <= 4'h0;
                    byte_seen_r <= 1'b1;
                end else begin
                    slot_cnt_r <= slot_cnt_r + 4'h1;
                end
            end
        end
    end

    // Stop or repeated start after a byte follows one setup rise
    assign misplaced = mst_busy_r && (line_evt.start || line_evt.stop) &&
                       (slot_cnt_r != 4'h0) &&
                       !(slot_cnt_r == 4'h1 && byte_seen_r);

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            no_ack_error_flag_r              <= 1'b0;
            arbitration_loss_error_flag_r    <= 1'b0;
            misplaced_condition_error_flag_r <= 1'b0;
            boot_checksum_error_flag_r       <= 1'b0;
        end else begin
            no_ack_error_flag_r <= MST_EVT_I.nack_unexp |
                (no_ack_error_flag_r & ~w1c_clr[smbsr_pkg::NACK_ERR_BIT]);
            arbitration_loss_error_flag_r <= arb_abort |
                (arbitration_loss_error_flag_r &
                 ~w1c_clr[smbsr_pkg::ARB_ERR_BIT]);
            misplaced_condition_error_flag_r <= misplaced |
                (misplaced_condition_error_flag_r &
                 ~w1c_clr[smbsr_pkg::MISPL_ERR_BIT]);
            boot_checksum_error_flag_r <= LOAD_EVT_I.csum_bad |
                LOAD_EVT_I.no_cfg_done |
                (boot_checksum_error_flag_r &
                 ~w1c_clr[smbsr_pkg::CSUM_ERR_BIT]);
        end
    end

    // Level interrupt, one cycle behind the flags
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(serial_bus_status_reg & irq_mask_r);
        end
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);

    logic status_rd;
    assign status_rd = bus_req && !WB_WE_I && !WB_ACK_O && hit_status;

    a_slv_addr_read: assert property (
        status_rd |=> WB_DAT_O[7:1] == $past(target_port_address_r))
        else $error("target address field wrong on read");

    a_mst_addr_read: assert property (
        status_rd |=> WB_DAT_O[15:9] == $past(initiator_port_address_r))
        else $error("initiator address field wrong on read");

    a_done_sets: assert property (
        boot_load_en_r && (LOAD_EVT_I.load_done || LOAD_EVT_I.csum_bad)
        |=> boot_load_finished_r [*2])
        else $error("finish flag not set after load end");

    a_done_mode_gate: assert property (
        !boot_load_en_r |-> !boot_load_finished_r)
        else $error("finish flag set outside loading mode");

    a_nack_flag: assert property (
        MST_EVT_I.nack_unexp |=> no_ack_error_flag_r)
        else $error("nack flag missed");

    a_arb_retry: assert property (
        MST_EVT_I.arb_lost && arb_loss_cnt_r < ARB_LAST
        |=> ARB_RETRY_O && !XFER_ABORT_O
            ##1 !ARB_RETRY_O || $past(MST_EVT_I.arb_lost))
        else $error("retry not issued after lost arbitration");

    a_arb_abort: assert property (
        MST_EVT_I.arb_lost && arb_loss_cnt_r == ARB_LAST
        |=> XFER_ABORT_O && arbitration_loss_error_flag_r
            && arb_loss_cnt_r == 5'h0)
        else $error("abort or flag missing at loss limit");

    a_misplaced_flag: assert property (
        mst_busy_r && line_evt.stop && slot_cnt_r == 4'h4
        |=> misplaced_condition_error_flag_r)
        else $error("misplaced stop not flagged");

    a_csum_flag: assert property (
        LOAD_EVT_I.no_cfg_done |=> boot_checksum_error_flag_r)
        else $error("checksum flag missed");

    a_rsvd_zero: assert property (
        status_rd |=> WB_DAT_O[31:29] == 3'h0 && WB_DAT_O[23:16] == 8'h00
                      && !WB_DAT_O[0] && !WB_DAT_O[8])
        else $error("reserved status bits not zero");

    a_irq_level: assert property (
        IRQ_O == $past(|(serial_bus_status_reg & irq_mask_r)))
        else $error("interrupt does not follow masked flags");

    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    c_abort_seen: cover property (XFER_ABORT_O);
    c_w1c_clear: cover property (
        no_ack_error_flag_r ##1 !no_ack_error_flag_r);
    c_irq_raised: cover property ($rose(IRQ_O));
    c_misplaced: cover property (misplaced);
    c_byte_stop: cover property (
        mst_busy_r && line_evt.stop && byte_seen_r);

endmodule

`default_nettype wire

// ---- tb/smbsr_tgt_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module smbsr_tgt_model (
    output var logic scl_o,
    output var logic sda_o
);
    // Pull-ups hold both lines high; clock stands between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Data bits change only with the clock low, start and stop with it high, 200 ns clock period
    task automatic frame(input int rises, input logic [31:0] pat);
        // Keep line edges off the core clock edges
        #5;
        sda_o = 1'b0;
        #100;
        for (int i = 0; i < rises; i++) begin
            scl_o = 1'b0;
            sda_o = pat[i];
            #100;
            scl_o = 1'b1;
            #100;
        end
        scl_o = 1'b0;
        sda_o = 1'b0;
        #100;
        scl_o = 1'b1;
        #100;
        sda_o = 1'b1;
        #100;
    endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic [6:0]  tstrap = 7'h00;
    logic [6:0]  istrap = 7'h00;
    logic        boot = 1'b0;
    logic        scl;
    logic        sda;
    logic        retry;
    logic        abort;
    logic        irq;
    logic [31:0] seed = 32'h0000_c829;
    logic [31:0] st;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          retries = 0;
    int          aborts = 0;
    logic [31:0] exp_q[$];
    smbsr_pkg::smbsr_mst_evt_t  mevt = '0;
    smbsr_pkg::smbsr_load_evt_t levt = '0;

    smbsr_tgt_model tgt (.scl_o(scl), .sda_o(sda));

    smbsr_top #(.ARB_LIMIT(16)) uut (
        .MCLK_I(clk), .NRST_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .TARGET_ADDR_STRAP_I(tstrap),
        .INITIATOR_ADDR_STRAP_I(istrap), .BOOT_LOAD_MODE_I(boot),
        .MST_EVT_I(mevt), .LOAD_EVT_I(levt), .MST_SCL_I(scl),
        .MST_SDA_I(sda), .ARB_RETRY_O(retry), .XFER_ABORT_O(abort),
        .IRQ_O(irq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Request held until the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000, 4'hf);
    endtask

    task automatic ev(input logic [3:0] m, input logic [2:0] l);
        @(posedge clk);
        mevt <= m;
        levt <= l;
        @(posedge clk);
        mevt <= '0;
        levt <= '0;
    endtask

    task automatic losses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            mevt <= 4'b0010;
        end
        @(posedge clk);
        mevt <= '0;
        repeat (2) @(posedge clk);
    endtask

    // Straps change only while reset is held
    task automatic do_reset(input logic b);
        @(posedge clk);
        rst_n <= 1'b0;
        boot <= b;
        seed = xs(seed);
        tstrap <= seed[6:0];
        istrap <= seed[14:8];
        st = {16'h0000, seed[14:8], 1'b0, seed[6:0], 1'b0};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (retry === 1'b1)
            retries++;
        if (abort === 1'b1)
            aborts++;
        if (ack === 1'b1 && we === 1'b0)
            chk(rdat, exp_q.pop_front());
        if (cycles >= 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        do_reset(1'b1);
        rd(8'hac, st);
        wb(1'b1, 8'hac, 32'hffff_ffff, 4'hf);
        rd(8'hac, st);
        rd(8'h40, 32'h0000_0000);
        ev(4'b0000, 3'b100);
        st[24] = 1'b1;
        rd(8'hac, st);
        ev(4'b0001, 3'b000);
        wb(1'b1, 8'hac, 32'hffff_ffff, 4'h7);
        rd(8'hac, st | 32'h0200_0000);
        wb(1'b1, 8'hac, 32'h0200_0000, 4'hf);
        rd(8'hac, st);
        wb(1'b1, 8'hb8, 32'hffff_ffff, 4'hf);
        rd(8'hb8, smbsr_pkg::ERR_FLAG_MASK);
        wb(1'b1, 8'hb8, 32'h0200_0000, 4'hf);
        ev(4'b0001, 3'b000);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'hac, 32'h0200_0000, 4'hf);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        losses(5);
        ev(4'b0100, 3'b000);
        losses(15);
        chk(aborts, 0);
        losses(16);
        chk(retries, 35);
        chk(aborts, 1);
        rd(8'hac, st | 32'h0400_0000);
        wb(1'b1, 8'hac, 32'h0400_0000, 4'hf);
        ev(4'b1000, 3'b000);
        seed = xs(seed);
        tgt.frame(9, seed);
        repeat (8) @(posedge clk);
        rd(8'hac, st);
        ev(4'b1000, 3'b000);
        tgt.frame(3, seed);
        repeat (8) @(posedge clk);
        rd(8'hac, st | 32'h0800_0000);
        wb(1'b1, 8'hac, 32'h0800_0000, 4'hf);
        ev(4'b0000, 3'b010);
        rd(8'hac, st | 32'h1000_0000);
        wb(1'b1, 8'hac, 32'h1000_0000, 4'hf);
        ev(4'b0000, 3'b001);
        rd(8'hac, st | 32'h1000_0000);
        do_reset(1'b0);
        ev(4'b0000, 3'b100);
        rd(8'hac, st);
        repeat (2) @(posedge clk);
        chk(exp_q.size(), 0);
        close_out();
    end
endmodule

`default_nettype wire
